// *** verilog/alarm_pkg.sv ***
// shared constants and types for the servo alarm manager
package alarm_pkg;
    // alarm and warning codes, 12-bit display value (888 uses three digits)
    localparam logic [11:0] CODE_NONE = 12'h000;
    localparam logic [11:0] CODE_WATCHDOG = 12'h888;
    localparam logic [11:0] CODE_UNDERVOLT = 12'h010;
    localparam int NUM_SRC = 32;
    localparam int NUM_WARN = 13;
    // clearing classes
    typedef enum logic [2:0] {
        CLR_ANY, CLR_POWER_ONLY, CLR_NO_ERR_RESET, CLR_THERMAL, CLR_LOCKOUT, CLR_NEVER
    } clear_class_t;
    // clock and timing
    localparam int CLK_HZ = 10_000_000;
    localparam int CTRL_LOSS_MS = 60;
    localparam int CTRL_LOSS_CYC = CTRL_LOSS_MS * (CLK_HZ / 1000);
    // bus undervoltage thresholds in volts
    localparam logic [9:0] BUS_UV_HIGH_V = 10'h0c8;
    localparam logic [9:0] BUS_UV_LOW_V = 10'h09e;
    // lockout: load history scales a base interval
    localparam int LOCK_BASE_MIN = 30;
    // cycles per load unit; 64-bit math, the plain product overflows an int
    localparam int unsigned LOCK_UNIT_CYC =
        32'(64'(LOCK_BASE_MIN) * 64'h3c * 64'(CLK_HZ) / 64'h100);
    localparam logic [7:0] LOAD_RESET = 8'h00;
    localparam logic [31:0] ZERO32 = 32'h0000_0000;
endpackage : alarm_pkg

// *** verilog/alarm_clear_if.sv ***
// clear request bundle between the manager and its lockout timer
`timescale 1ns/1ps
interface alarm_clear_if;
    logic start;
    logic [7:0] load;
    logic busy;
    modport mgr (output start, output load, input busy);
    modport tmr (input start, input load, output busy);
endinterface : alarm_clear_if

// *** verilog/lockout_timer.sv ***
// cooling lockout timer for the thermal overload alarms
`timescale 1ns/1ps
module lockout_timer
    import alarm_pkg::*;
#(
    parameter int unsigned LOCK_CYC = LOCK_UNIT_CYC
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic clk_en,
    alarm_clear_if.tmr clr
);
    logic [39:0] count_q;

    // interval grows with the load seen before the alarm
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            count_q <= 40'h00_0000_0000;
        end else if (clk_en) begin
            if (clr.start) begin
                count_q <= 40'(LOCK_CYC) * (40'(clr.load) + 40'h00_0000_0001);
            end else if (count_q != 40'h00_0000_0000) begin
                count_q <= count_q - 40'h00_0000_0001;
            end
        end
    end

    assign clr.busy = (count_q != 40'h00_0000_0000);
endmodule : lockout_timer

// *** verilog/servo_alarm_manager.sv ***
// alarm latch, clearing policy and display for the servo driver
// Summary of operation
// - any active alarm drives the trouble output off until the alarm is cleared.
// - any alarm engages the dynamic brake and shows the alarm code on the display.
// - codes 10,24,31,33,35,36,52,8A,8E clear by power cycle, error reset or CPU reset.
// - codes 12,13,15,16,17,19,1A,20,25,32,37,47 clear only by power cycle.
// - code 34 clears by power cycle or CPU reset; error reset clears it only while comm_ok is high.
// - alarms 30,50,51 reject controller clears until a load-derived lockout ends.
// - warning codes are reported as a separate class on the same display.
// - alarm 10 rises on 60 ms control power loss or bus voltage at or below threshold.
`timescale 1ns/1ps
module servo_alarm_manager
    import alarm_pkg::*;
#(
    parameter int unsigned CTRL_LOSS_LIMIT = CTRL_LOSS_CYC,
    parameter int unsigned LOCK_CYC = LOCK_UNIT_CYC
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic clk_en,
    input wire logic [NUM_SRC-1:0] fault_in,
    input wire logic [NUM_WARN-1:0] warn_in,
    input wire logic ctrl_power_ok,
    input wire logic [9:0] bus_volt,
    input wire logic low_volt_variant,
    input wire logic [7:0] load_level,
    input wire logic watchdog_fault,
    input wire logic err_reset_cmd,
    input wire logic cpu_reset_cmd,
    input wire logic comm_ok,
    output logic trouble_output,
    output logic dyn_brake,
    output logic alarm_active,
    output logic warn_active,
    output logic [11:0] display_code
);
    // source table: index to display code and clearing class
    localparam logic [7:0] ALARM_CODES [NUM_SRC] = '{
        8'h10, 8'h12, 8'h13, 8'h15, 8'h16, 8'h17, 8'h19, 8'h1a,
        8'h20, 8'h24, 8'h25, 8'h30, 8'h31, 8'h32, 8'h33, 8'h34,
        8'h35, 8'h36, 8'h37, 8'h45, 8'h46, 8'h47, 8'h50, 8'h51,
        8'h52, 8'h8a, 8'h8e, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00
    };
    localparam logic [7:0] WARN_CODES [NUM_WARN] = '{
        8'h92, 8'h96, 8'h9f, 8'he0, 8'he1, 8'he3, 8'he4,
        8'he6, 8'he7, 8'he8, 8'he9, 8'hec, 8'hed
    };

    function automatic clear_class_t class_of(input logic [7:0] code);
        unique case (code)
            8'h10, 8'h24, 8'h31, 8'h33, 8'h35, 8'h36, 8'h52, 8'h8a, 8'h8e:
                class_of = CLR_ANY;
            8'h34: class_of = CLR_NO_ERR_RESET;
            8'h45, 8'h46: class_of = CLR_THERMAL;
            8'h30, 8'h50, 8'h51: class_of = CLR_LOCKOUT;
            8'h00: class_of = CLR_NEVER;
            default: class_of = CLR_POWER_ONLY;
        endcase
    endfunction : class_of

    // fault, warning, bus voltage and the three status pins pass two flip-flops first; load and command pins do not
    logic [NUM_SRC-1:0] fault_m_q, fault_s_q;
    logic [NUM_WARN-1:0] warn_m_q, warn_s_q;
    logic [2:0] misc_m_q, misc_s_q;
    logic [9:0] volt_m_q, volt_s_q;
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            fault_m_q <= '0;
            fault_s_q <= '0;
            warn_m_q <= '0;
            warn_s_q <= '0;
            misc_m_q <= 3'h1;
            misc_s_q <= 3'h1;
            volt_m_q <= 10'h3ff;
            volt_s_q <= 10'h3ff;
        end else if (clk_en) begin
            fault_m_q <= fault_in;
            fault_s_q <= fault_m_q;
            warn_m_q <= warn_in;
            warn_s_q <= warn_m_q;
            misc_m_q <= {watchdog_fault, low_volt_variant, ctrl_power_ok};
            misc_s_q <= misc_m_q;
            volt_m_q <= bus_volt;
            volt_s_q <= volt_m_q;
        end
    end

    // undervoltage detection
    logic [31:0] loss_cnt_q;
    logic undervolt;
    logic [9:0] uv_limit;
    assign uv_limit = misc_s_q[1] ? BUS_UV_LOW_V : BUS_UV_HIGH_V;
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            loss_cnt_q <= ZERO32;
        end else if (clk_en) begin
            if (misc_s_q[0]) begin
                loss_cnt_q <= ZERO32;
            end else if (loss_cnt_q < CTRL_LOSS_LIMIT) begin
                loss_cnt_q <= loss_cnt_q + 32'h0000_0001;
            end
        end
    end
    assign undervolt = (loss_cnt_q >= CTRL_LOSS_LIMIT) || (volt_s_q <= uv_limit);

    // load history seen before the alarm, for the lockout length
    logic [7:0] load_q;
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            load_q <= LOAD_RESET;
        end else if (clk_en && !alarm_active) begin
            load_q <= (load_level > load_q) ? load_level : load_q - {7'h00, |load_q};
        end
    end

    // lockout timer shared by alarms 30, 50, 51
    alarm_clear_if clr_bus ();
    lockout_timer #(.LOCK_CYC(LOCK_CYC)) u_lock (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .clk_en(clk_en),
        .clr(clr_bus.tmr)
    );

    // latched alarms; power cycle is arst_n, a fault still present relatches after it
    logic [NUM_SRC-1:0] latch_q;
    logic [NUM_SRC-1:0] raw;
    logic [NUM_SRC-1:0] clear_mask;
    logic any_new_lock;
    logic wdog_q;
    always_comb begin
        raw = fault_s_q;
        raw[0] = fault_s_q[0] | undervolt;
        any_new_lock = 1'b0;
        clear_mask = '0;
        for (int i = 0; i < NUM_SRC; i++) begin
            if (raw[i] && !latch_q[i] && class_of(ALARM_CODES[i]) == CLR_LOCKOUT) begin
                any_new_lock = 1'b1;
            end
            unique case (class_of(ALARM_CODES[i]))
                CLR_ANY: clear_mask[i] = err_reset_cmd | cpu_reset_cmd;
                CLR_NO_ERR_RESET:
                    clear_mask[i] = cpu_reset_cmd | (err_reset_cmd & comm_ok);
                CLR_THERMAL: clear_mask[i] = err_reset_cmd | cpu_reset_cmd;
                CLR_LOCKOUT:
                    clear_mask[i] = (err_reset_cmd | cpu_reset_cmd) & !clr_bus.busy;
                CLR_POWER_ONLY: clear_mask[i] = 1'b0;
                CLR_NEVER: clear_mask[i] = 1'b0;
            endcase
        end
    end
    assign clr_bus.start = clk_en & any_new_lock;
    assign clr_bus.load = load_q;

    // a fault still present sets again, so set wins over clear
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            latch_q <= '0;
        end else if (clk_en) begin
            latch_q <= (latch_q & ~clear_mask) | raw;
        end
    end

    // watchdog: sticky against error reset and CPU reset, cleared only by power cycle
    logic wdog_seen_q;
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            wdog_q <= 1'b0;
            wdog_seen_q <= 1'b0;
        end else if (clk_en) begin
            wdog_seen_q <= misc_s_q[2];
            if (wdog_seen_q) begin
                wdog_q <= 1'b1;
            end
        end
    end

    // watchdog wins the display, then lowest-index alarm, then lowest warning
    logic [11:0] code_d;
    logic any_alarm, any_warn;
    always_comb begin
        code_d = CODE_NONE;
        any_alarm = wdog_q | (|latch_q);
        any_warn = |warn_s_q;
        for (int i = NUM_WARN - 1; i >= 0; i--) begin
            if (warn_s_q[i]) begin
                code_d = {4'h0, WARN_CODES[i]};
            end
        end
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (latch_q[i]) begin
                code_d = {4'h0, ALARM_CODES[i]};
            end
        end
        if (wdog_q) begin
            code_d = CODE_WATCHDOG;
        end
    end

    // outputs from flip-flops; trouble output is high when healthy
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            trouble_output <= 1'b1;
            dyn_brake <= 1'b0;
            alarm_active <= 1'b0;
            warn_active <= 1'b0;
            display_code <= CODE_NONE;
        end else if (clk_en) begin
            trouble_output <= !any_alarm;
            dyn_brake <= any_alarm;
            alarm_active <= any_alarm;
            warn_active <= any_warn & !any_alarm;
            display_code <= code_d;
        end
    end
endmodule : servo_alarm_manager

// *** tb/ctrl_model.sv ***
// controller model that issues the reset commands on request
`timescale 1ns/1ps
module ctrl_model (
    input wire logic clk_sys,
    input wire logic [1:0] req,
    output logic err_reset_cmd,
    output logic cpu_reset_cmd
);
    // outputs settle at the first edge, which falls inside the opening reset
    // the bench asks once the cause is gone, both before and after the cooling wait
    always @(posedge clk_sys) begin
        err_reset_cmd <= #1 req[0];
        cpu_reset_cmd <= #1 req[1];
    end
endmodule : ctrl_model

// *** tb/sam_chk.sv ***
// port assertions for the alarm manager
`timescale 1ns/1ps
module sam_chk
    import alarm_pkg::*;
(
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic [NUM_SRC-1:0] fault_in,
    input wire logic [9:0] bus_volt,
    input wire logic low_volt_variant,
    input wire logic [7:0] load_level,
    input wire logic err_reset_cmd,
    input wire logic cpu_reset_cmd,
    input wire logic comm_ok,
    input wire logic trouble_output,
    input wire logic dyn_brake,
    input wire logic alarm_active,
    input wire logic warn_active,
    input wire logic [11:0] display_code
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    logic cmd;
    assign cmd = err_reset_cmd || cpu_reset_cmd;
    a_trouble_off: assert property (alarm_active != trouble_output)
        else $error("trouble output disagrees with alarm state");
    a_brake_shown: assert property (alarm_active |-> dyn_brake && display_code != 12'h000)
        else $error("alarm without brake or code");
    a_any_clear: assert property ((fault_in == 32'h0)[*4] ##0
        (display_code == 12'h031 && cmd) |-> ##2 !alarm_active)
        else $error("clearable alarm stayed");
    a_power_only: assert property (display_code == 12'h012 && cmd |-> ##2 alarm_active)
        else $error("power-only alarm cleared by command");
    a_rx_gate: assert property (display_code == 12'h034 && err_reset_cmd && !comm_ok
        && !cpu_reset_cmd |-> ##2 alarm_active)
        else $error("receive error cleared without link");
    a_thermal_lock: assert property ($rose(alarm_active) && display_code == 12'h050
        && load_level >= 8'h20 ##[1:6] cmd |-> ##2 alarm_active)
        else $error("thermal alarm cleared during lockout");
    a_warn_class: assert property (warn_active |->
        trouble_output && display_code[7:4] >= 4'h9)
        else $error("warning shown as alarm");
    a_bus_low: assert property ((bus_volt <= 10'h0c8 && !low_volt_variant)[*7]
        |-> alarm_active && display_code == 12'h010)
        else $error("bus undervoltage not raised");
    a_wd_hold: assert property (display_code == 12'h888 |=> display_code == 12'h888)
        else $error("watchdog alarm released");
    cover property ($fell(alarm_active));
    cover property (display_code == 12'h888);
    cover property (warn_active);
endmodule : sam_chk
bind servo_alarm_manager sam_chk chk_u (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .fault_in(fault_in),
    .bus_volt(bus_volt),
    .low_volt_variant(low_volt_variant),
    .load_level(load_level),
    .err_reset_cmd(err_reset_cmd),
    .cpu_reset_cmd(cpu_reset_cmd),
    .comm_ok(comm_ok),
    .trouble_output(trouble_output),
    .dyn_brake(dyn_brake),
    .alarm_active(alarm_active),
    .warn_active(warn_active),
    .display_code(display_code)
);

// *** tb/servo_alarm_manager_tb.sv ***
// self-checking bench for the alarm manager
`timescale 1ns/1ps
module servo_alarm_manager_tb;
    import alarm_pkg::*;
    logic clk_sys = 0, arst_n = 0, ctrl_power_ok = 1, low_volt_variant = 0;
    logic watchdog_fault = 0, comm_ok = 1, err_reset_cmd, cpu_reset_cmd;
    logic clk_en = 1'b1;
    logic trouble_output, dyn_brake, alarm_active, warn_active;
    logic [31:0] fault_in = 32'h0;
    logic [12:0] warn_in = 13'h0;
    logic [9:0] bus_volt = 10'h12c;
    logic [7:0] load_level = 8'h00;
    logic [1:0] req = 2'h0;
    logic [11:0] display_code;
    int fail_count = 0, num_checks = 0, warn_now = -1;
    bit lat[27];
    bit wd = 0;
    int acode[27] = '{8'h10, 8'h12, 8'h13, 8'h15, 8'h16, 8'h17, 8'h19, 8'h1a, 8'h20, 8'h24,
        8'h25, 8'h30, 8'h31, 8'h32, 8'h33, 8'h34, 8'h35, 8'h36, 8'h37, 8'h45, 8'h46, 8'h47,
        8'h50, 8'h51, 8'h52, 8'h8a, 8'h8e};
    int wcode[13] = '{8'h92, 8'h96, 8'h9f, 8'he0, 8'he1, 8'he3, 8'he4, 8'he6, 8'he7, 8'he8,
        8'he9, 8'hec, 8'hed};
    always #50 clk_sys = ~clk_sys;
    // short counts keep the lockout and power-loss waits small
    servo_alarm_manager #(.CTRL_LOSS_LIMIT(10), .LOCK_CYC(4)) dut_u (.clk_sys(clk_sys),
        .arst_n(arst_n), .clk_en(clk_en), .fault_in(fault_in), .warn_in(warn_in),
        .ctrl_power_ok(ctrl_power_ok), .bus_volt(bus_volt), .low_volt_variant(low_volt_variant),
        .load_level(load_level), .watchdog_fault(watchdog_fault), .err_reset_cmd(err_reset_cmd),
        .cpu_reset_cmd(cpu_reset_cmd), .comm_ok(comm_ok), .trouble_output(trouble_output),
        .dyn_brake(dyn_brake), .alarm_active(alarm_active), .warn_active(warn_active),
        .display_code(display_code));
    ctrl_model ctl_u (.clk_sys(clk_sys), .req(req), .err_reset_cmd(err_reset_cmd),
        .cpu_reset_cmd(cpu_reset_cmd));
    task cyc(int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : cyc
    task stop_test;
        $display("checks %0d errors %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : stop_test
    task chk;
        logic [15:0] e, g;
        int lo;
        lo = -1;
        for (int i = 26; i >= 0; i--) if (lat[i]) lo = i;
        e[11:0] = wd ? 12'h888 : lo >= 0 ? 12'(acode[lo]) :
            warn_now >= 0 ? 12'(wcode[warn_now]) : 12'h000;
        e[15:12] = {!(wd || lo >= 0), wd || lo >= 0, wd || lo >= 0, !wd && lo < 0 && warn_now >= 0};
        g = {trouble_output, dyn_brake, alarm_active, warn_active, display_code};
        num_checks++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR t=%0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    function bit ok(int c, bit cpu, bit early);
        if (c inside {8'h12, 8'h13, 8'h15, 8'h16, 8'h17, 8'h19, 8'h1a, 8'h20, 8'h25, 8'h32,
            8'h37, 8'h47}) return 0;
        if (c == 8'h34) return cpu || comm_ok;
        if (c inside {8'h30, 8'h50, 8'h51}) return !early;
        return 1;
    endfunction : ok
    task clr(bit cpu, bit early);
        for (int i = 0; i < 27; i++) if (lat[i] && ok(acode[i], cpu, early)) lat[i] = 0;
        req[cpu] = 1'b1;
        cyc(1);
        req = 2'h0;
        cyc(4);
    endtask : clr
    task pwr;
        arst_n = 1'b0;
        cyc(2);
        arst_n = 1'b1;
        lat = '{default: 0};
        wd = 0;
        cyc(2);
    endtask : pwr
    initial begin
        #2_000_000;
        fail_count++;
        stop_test;
    end
    initial begin
        void'($urandom(32'h11fa));
        cyc(8);
        arst_n = 1'b1;
        cyc(2);
        for (int i = 0; i < 27; i++) begin
            load_level = 8'h20 + 8'($urandom % 4);
            // code 34 sees a dead link here so the gated error reset is exercised
            comm_ok = (i == 15) ? 1'b0 : 1'($urandom);
            cyc(3);
            fault_in[i] = 1'b1;
            cyc(1);
            fault_in[i] = 1'b0;
            lat[i] = 1;
            cyc(5);
            chk;
            clr(0, 1);
            chk;
            cyc(160);
            clr(1, 0);
            chk;
            pwr;
            chk;
        end
        for (int w = 0; w < 13; w++) begin
            warn_in[w] = 1'b1;
            warn_now = w;
            cyc(5);
            chk;
            warn_in[w] = 1'b0;
            warn_now = -1;
            cyc(5);
        end
        // a frozen block must not see a fault that comes and goes meanwhile
        clk_en = 1'b0;
        fault_in[12] = 1'b1;
        cyc(4);
        fault_in[12] = 1'b0;
        cyc(2);
        clk_en = 1'b1;
        cyc(5);
        chk;
        comm_ok = 1'b1;
        fault_in[15] = 1'b1;
        cyc(1);
        fault_in[15] = 1'b0;
        lat[15] = 1;
        cyc(5);
        chk;
        clr(0, 0);
        chk;
        bus_volt = 10'h0c8;
        lat[0] = 1;
        cyc(10);
        chk;
        bus_volt = 10'h12c;
        low_volt_variant = 1'b1;
        cyc(4);
        clr(1, 0);
        bus_volt = 10'h09f;
        cyc(10);
        chk;
        bus_volt = 10'h09e;
        lat[0] = 1;
        cyc(10);
        chk;
        bus_volt = 10'h12c;
        cyc(4);
        clr(0, 0);
        ctrl_power_ok = 1'b0;
        cyc(6);
        ctrl_power_ok = 1'b1;
        cyc(6);
        chk;
        ctrl_power_ok = 1'b0;
        cyc(16);
        ctrl_power_ok = 1'b1;
        lat[0] = 1;
        cyc(6);
        chk;
        pwr;
        watchdog_fault = 1'b1;
        cyc(1);
        watchdog_fault = 1'b0;
        wd = 1;
        cyc(5);
        clr(0, 0);
        clr(1, 0);
        chk;
        pwr;
        chk;
        stop_test;
    end
endmodule : servo_alarm_manager_tb
